// ### bul_limits.sv
// bul_limits: buffer usage thresholds, flow control triggers, drop stats
`timescale 1ns/10ps
`default_nettype none

module bul_limits #(
   parameter int CW = bul_pkg::CNT_W
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic [bul_pkg::ADDR_W-1:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire bul_pkg::bul_usage_t usage,
   input wire logic [bul_pkg::BUF_W-1:0] flood_usage,
   input wire bul_pkg::bul_ingress_s ing,
   output logic [bul_pkg::NPORT-1:0] drop_pkt,
   output logic [bul_pkg::NPORT-1:0] pause_req,
   output logic [bul_pkg::NPORT-1:0] resume_req,
   output logic [bul_pkg::NPORT-1:0] paused,
   output logic flood_full
);
   import bul_pkg::*;

   bul_state_s s;
   bul_state_s next_s;
   logic [1:0] act_n;
   logic multi;
   logic [LVL_W-1:0] lim;
   logic [LVL_W-1:0] pl;
   logic [LVL_W-1:0] rl;
   logic fl_full;
   logic [NPORT-1:0] drop_now;
   logic [NPORT-1:0] rd_clr;
   logic [NPORT-1:0][CW-1:0] cnt;
   logic [32:0] rd_word;
   logic capture;
   logic done;

   // counters and address map assume full 32-bit words
   if (CW != CNT_W) begin
      $error("bul_limits: CW must equal CNT_W");
   end

   // number of ports holding at least the active level of buffers
   function automatic logic [1:0] n_active(input bul_usage_t u);
      logic [1:0] n;
      n = 2'h0;
      for (int p = 0; p < NPORT; p++) begin
         n = n + {1'b0, at_or_above(u[p], ACTIVE_LVL[LVL_W-1:0])};
      end
      return n;
   endfunction

   // read decode: bit 32 flags a mapped address
   function automatic logic [32:0] read_map(
      input logic [ADDR_W-1:0] a,
      input bul_state_s st,
      input logic [NPORT-1:0][CW-1:0] c);
      logic [32:0] r;
      r = 33'h0_0000_0000;
      unique case (a)
         A_DROP: begin
            r = {1'b1, 16'h0000, st.drop_lo, st.drop_hi};
         end
         A_PAUSE: begin
            r = {1'b1, 16'h0000, st.pause_lo, st.pause_hi};
         end
         A_RESUME: begin
            r = {1'b1, 16'h0000, st.res_lo, st.res_hi};
         end
         A_FLOOD: begin
            r = {1'b1, 24'h00_0000, st.flood};
         end
         A_CNT0: begin
            r = {1'b1, c[0]};
         end
         A_CNT1: begin
            r = {1'b1, c[1]};
         end
         A_CNT2: begin
            r = {1'b1, c[2]};
         end
         A_CTRL: begin
            r = {1'b1, 29'h0000_0000, st.test, st.yel_en, st.red_en};
         end
         default: begin
            r = 33'h0_0000_0000;
         end
      endcase
      return r;
   endfunction

   // threshold set follows the live active count, no hysteresis
   assign act_n = n_active(usage);
   assign multi = act_n >= 2'h2;
   assign lim = multi ? s.drop_lo : s.drop_hi;
   assign pl = multi ? s.pause_lo : s.pause_hi;
   assign rl = multi ? s.res_lo : s.res_hi;
   assign fl_full = at_or_above(flood_usage, s.flood);

   // discard decision per port for a packet starting this cycle
   always_comb begin
      for (int p = 0; p < NPORT; p++) begin
         drop_now[p] = ing.start[p] & (
            at_or_above(usage[p], lim)
            | (ing.flood[p] & fl_full)
            | (ing.red[p] & s.red_en)
            | (ing.yellow[p] & ing.rnd_hit[p] & s.yel_en));
      end
   end

   // no wait state: data is latched in the setup phase, then pready is offered;
   // holding ce low stretches the access instead of losing it
   assign rd_word = read_map(paddr, s, cnt);
   assign capture = psel & ~s.got;
   assign done = psel & penable & s.got & ce;
   assign pready = penable & s.got & ce;

   // a counter clears, or loads the test preset, on the edge its value is latched for the bus
   always_comb begin
      for (int p = 0; p < NPORT; p++) begin
         rd_clr[p] = 1'b0;
      end
      rd_clr[0] = capture & ~pwrite & (paddr == A_CNT0);
      rd_clr[1] = capture & ~pwrite & (paddr == A_CNT1);
      rd_clr[2] = capture & ~pwrite & (paddr == A_CNT2);
   end

   // next state of thresholds, flow control, bus response
   always_comb begin
      next_s = s;
      next_s.pause_req = '0;
      next_s.resume_req = '0;
      next_s.drop = drop_now;
      // pause once the level is reached, release at the resume level
      for (int p = 0; p < NPORT; p++) begin
         if (!s.paused[p] && at_or_above(usage[p], pl)) begin
            next_s.pause_req[p] = 1'b1;
            next_s.paused[p] = 1'b1;
         end else if (s.paused[p] && usage[p] <= {1'b0, rl}) begin
            next_s.resume_req[p] = 1'b1;
            next_s.paused[p] = 1'b0;
         end
      end
      // setup phase: latch read data and the error answer
      if (capture) begin
         next_s.got = 1'b1;
         next_s.rdata = pwrite ? 32'h0000_0000 : rd_word[31:0];
         next_s.slverr = ~rd_word[32] | (paddr[1:0] != 2'h0);
      end
      // access completes; writes take effect on this edge only
      if (done) begin
         next_s.got = 1'b0;
         if (pwrite) begin
            unique case (paddr)
               A_DROP: begin
                  next_s.drop_lo = pwdata[LO_LSB +: LVL_W];
                  next_s.drop_hi = pwdata[HI_LSB +: LVL_W];
               end
               A_PAUSE: begin
                  next_s.pause_lo = pwdata[LO_LSB +: LVL_W];
                  next_s.pause_hi = pwdata[HI_LSB +: LVL_W];
               end
               A_RESUME: begin
                  next_s.res_lo = pwdata[LO_LSB +: LVL_W];
                  next_s.res_hi = pwdata[HI_LSB +: LVL_W];
               end
               A_FLOOD: begin
                  next_s.flood = pwdata[HI_LSB +: LVL_W];
               end
               A_CTRL: begin
                  next_s.red_en = pwdata[CTRL_RED_BIT];
                  next_s.yel_en = pwdata[CTRL_YEL_BIT];
                  next_s.test = pwdata[CTRL_TEST_BIT];
               end
               default: begin
                  next_s.got = 1'b0; // counters and unmapped: no store
               end
            endcase
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s <= RST_STATE;
      end else if (ce) begin
         s <= next_s;
      end
   end

   // one counter per source port
   for (genvar p = 0; p < NPORT; p++) begin : g_cnt
      bul_drop_counter #(
         .CW(CW)
      ) u_cnt (
         .pclk(pclk),
         .presetn(presetn),
         .ce(ce),
         .inc(drop_now[p]),
         .rd_clr(rd_clr[p]),
         .test(s.test),
         .count(cnt[p])
      );
   end

   assign prdata = s.rdata;
   assign pslverr = pready & s.slverr;
   assign drop_pkt = s.drop;
   assign pause_req = s.pause_req;
   assign resume_req = s.resume_req;
   assign paused = s.paused;
   assign flood_full = fl_full;

   drop_limit_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      ce && ing.start[0] && at_or_above(usage[0], lim) |=> drop_pkt[0])
      else $error("over-limit packet not dropped");

   multi_sel_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      at_or_above(usage[0], 8'h24) && at_or_above(usage[1], 8'h24)
      |-> lim == s.drop_lo && pl == s.pause_lo && rl == s.res_lo)
      else $error("low thresholds not selected");

   single_sel_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      usage[0] < 9'h024 && usage[1] < 9'h024 |->
      lim == s.drop_hi && pl == s.pause_hi && rl == s.res_hi)
      else $error("high thresholds not selected");

   pause_trig_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      ce && !paused[1] && at_or_above(usage[1], pl) |=>
      pause_req[1] && paused[1] ##1 (!pause_req[1] || !$past(ce)))
      else $error("pause not raised at pause level");

   // a frozen cycle may stretch the pulse, so only a live edge clears it
   no_repause_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      ce && paused[1] |=> !pause_req[1])
      else $error("pause raised again while paused");

   pause_low_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      ce && !paused[2] && multi && at_or_above(usage[2], s.pause_lo)
      |=> pause_req[2] && paused[2])
      else $error("low pause level ignored");

   pause_high_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      ce && !paused[0] && !multi && at_or_above(usage[0], s.pause_hi)
      |=> pause_req[0] && paused[0])
      else $error("high pause level ignored");

   resume_high_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      ce && paused[0] && !multi && usage[0] <= {1'b0, s.res_hi}
      |=> resume_req[0] && !paused[0])
      else $error("high resume level ignored");

   resume_trig_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      $rose(resume_req[2]) |-> $past(paused[2]) && !paused[2])
      else $error("resume without prior pause");

   flood_cap_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      ce && ing.start[0] && ing.flood[0] && flood_usage >= {1'b0, s.flood}
      |=> drop_pkt[0])
      else $error("flooded packet above limit kept");

   red_gate_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      ce && ing.start[1] && ing.red[1] && s.red_en |=> drop_pkt[1])
      else $error("red packet kept while drop-on-red set");

   // with no other reason to drop, a red packet passes when disabled
   red_kept_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      ce && ing.start[2] && ing.red[2] && !s.red_en && !ing.yellow[2]
      && !ing.flood[2] && !at_or_above(usage[2], lim) |=> !drop_pkt[2])
      else $error("red packet dropped while drop-on-red clear");

   yellow_drop_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      ce && ing.start[2] && ing.yellow[2] && ing.rnd_hit[2] && s.yel_en
      |=> drop_pkt[2])
      else $error("yellow random hit kept while drop-on-yellow set");

   rd_clear_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      ce && capture && !pwrite && paddr == A_CNT1 && !drop_now[1]
      && !s.test |=> cnt[1] == CNT_RST)
      else $error("counter read did not clear it");

   reserved_rd_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      pready && !pwrite && paddr == A_DROP |-> prdata[31:16] == 16'h0000)
      else $error("reserved bits read nonzero");

   pause_resume_c: cover property (
      @(posedge pclk) disable iff (!presetn)
      pause_req[0] ##[1:200] resume_req[0]);

   count_read_c: cover property (
      @(posedge pclk) disable iff (!presetn)
      pready && !pwrite && paddr == A_CNT0 && prdata != 32'h0000_0000);

   flood_drop_c: cover property (
      @(posedge pclk) disable iff (!presetn)
      fl_full && ing.start[2] && ing.flood[2]);

   ce_hold_c: cover property (
      @(posedge pclk) disable iff (!presetn)
      !ce && ing.start[0]);

endmodule
`default_nettype wire

// ### bul_pkg.sv
// bul_pkg: constants, types and helpers of the buffer usage limit block
package bul_pkg;

   // sizes
   localparam int NPORT = 3;
   localparam int BUF_W = 9;
   localparam int LVL_W = 8;
   localparam int CNT_W = 32;
   localparam int ADDR_W = 16;
   localparam int BUF_BYTES = 128;

   // a port counts as active from this many buffers in use
   localparam logic [BUF_W-1:0] ACTIVE_LVL = 9'h024;

   // register indices; byte address is four times the index
   localparam logic [ADDR_W-1:0] IDX_DROP = 16'h1C01;
   localparam logic [ADDR_W-1:0] IDX_PAUSE = 16'h1C02;
   localparam logic [ADDR_W-1:0] IDX_RESUME = 16'h1C03;
   localparam logic [ADDR_W-1:0] IDX_FLOOD = 16'h1C04;
   localparam logic [ADDR_W-1:0] IDX_CNT0 = 16'h1C05;
   localparam logic [ADDR_W-1:0] IDX_CNT1 = 16'h1C06;
   localparam logic [ADDR_W-1:0] IDX_CNT2 = 16'h1C07;
   localparam logic [ADDR_W-1:0] IDX_CTRL = 16'h1C0F;

   function automatic logic [ADDR_W-1:0] byte_addr(
      input logic [ADDR_W-1:0] idx);
      return idx << 2;
   endfunction

   localparam logic [ADDR_W-1:0] A_DROP = byte_addr(IDX_DROP);
   localparam logic [ADDR_W-1:0] A_PAUSE = byte_addr(IDX_PAUSE);
   localparam logic [ADDR_W-1:0] A_RESUME = byte_addr(IDX_RESUME);
   localparam logic [ADDR_W-1:0] A_FLOOD = byte_addr(IDX_FLOOD);
   localparam logic [ADDR_W-1:0] A_CNT0 = byte_addr(IDX_CNT0);
   localparam logic [ADDR_W-1:0] A_CNT1 = byte_addr(IDX_CNT1);
   localparam logic [ADDR_W-1:0] A_CNT2 = byte_addr(IDX_CNT2);
   localparam logic [ADDR_W-1:0] A_CTRL = byte_addr(IDX_CTRL);

   // field positions
   localparam int LO_LSB = 8;
   localparam int HI_LSB = 0;
   localparam int CTRL_RED_BIT = 0;
   localparam int CTRL_YEL_BIT = 1;
   localparam int CTRL_TEST_BIT = 2;

   // values after reset
   localparam logic [LVL_W-1:0] RST_DROP_LO = 8'h49;
   localparam logic [LVL_W-1:0] RST_DROP_HI = 8'h64;
   localparam logic [LVL_W-1:0] RST_PAUSE_LO = 8'h21;
   localparam logic [LVL_W-1:0] RST_PAUSE_HI = 8'h3C;
   localparam logic [LVL_W-1:0] RST_RES_LO = 8'h03;
   localparam logic [LVL_W-1:0] RST_RES_HI = 8'h07;
   localparam logic [LVL_W-1:0] RST_FLOOD = 8'h31;
   localparam logic [CNT_W-1:0] CNT_RST = 32'h0000_0000;
   localparam logic [CNT_W-1:0] CNT_PRESET = 32'h7FFF_FFFC;
   localparam logic [CNT_W-1:0] CNT_MAX = 32'hFFFF_FFFF;

   typedef logic [NPORT-1:0][BUF_W-1:0] bul_usage_t;

   // per-port packet events from the ingress side
   typedef struct packed {
      logic [NPORT-1:0] start;
      logic [NPORT-1:0] red;
      logic [NPORT-1:0] yellow;
      logic [NPORT-1:0] rnd_hit;
      logic [NPORT-1:0] flood;
   } bul_ingress_s;

   typedef struct packed {
      logic [LVL_W-1:0] drop_lo;
      logic [LVL_W-1:0] drop_hi;
      logic [LVL_W-1:0] pause_lo;
      logic [LVL_W-1:0] pause_hi;
      logic [LVL_W-1:0] res_lo;
      logic [LVL_W-1:0] res_hi;
      logic [LVL_W-1:0] flood;
      logic red_en;
      logic yel_en;
      logic test;
      logic [NPORT-1:0] paused;
      logic [NPORT-1:0] pause_req;
      logic [NPORT-1:0] resume_req;
      logic [NPORT-1:0] drop;
      logic got;
      logic [31:0] rdata;
      logic slverr;
   } bul_state_s;

   localparam bul_state_s RST_STATE = '{
      drop_lo: RST_DROP_LO, drop_hi: RST_DROP_HI,
      pause_lo: RST_PAUSE_LO, pause_hi: RST_PAUSE_HI,
      res_lo: RST_RES_LO, res_hi: RST_RES_HI,
      flood: RST_FLOOD, default: '0};

   typedef struct packed {
      logic [CNT_W-1:0] cnt;
   } bul_cnt_s;

   // usage and levels are both counts of 128-byte buffers
   function automatic logic at_or_above(input logic [BUF_W-1:0] u,
      input logic [LVL_W-1:0] l);
      return u >= {1'b0, l};
   endfunction

endpackage

// ### bul_drop_counter.sv
// bul_drop_counter: saturating drop counter, cleared on read, or preset on read in test mode
`timescale 1ns/10ps
`default_nettype none
module bul_drop_counter #(
   parameter int CW = bul_pkg::CNT_W
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic inc,
   input wire logic rd_clr,
   input wire logic test,
   output logic [CW-1:0] count
);
   import bul_pkg::*;

   bul_cnt_s s;
   bul_cnt_s next_s;

   // preset and saturation constants are fixed at the full width
   if (CW != CNT_W) begin
      $error("bul_drop_counter: CW must equal CNT_W");
   end

   // a drop in the read cycle lands on the fresh value, never lost
   always_comb begin
      next_s = s;
      if (rd_clr) begin
         next_s.cnt = (test ? CNT_PRESET : CNT_RST) + inc;
      end else if (inc && s.cnt != CNT_MAX) begin
         next_s.cnt = s.cnt + 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s <= '0;
      end else if (ce) begin
         s <= next_s;
      end
   end

   assign count = s.cnt;

   sat_hold_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      ce && !rd_clr && count == CNT_MAX |=> count == CNT_MAX)
      else $error("drop counter left saturation");

   clr_load_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      ce && rd_clr |=>
      count == (($past(test) ? CNT_PRESET : CNT_RST) + $past(inc)))
      else $error("drop counter read did not reload");

   count_step_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      ce && !rd_clr && inc && count != CNT_MAX |=>
      count == $past(count) + 1'b1)
      else $error("drop counter missed an increment");

endmodule
`default_nettype wire

// ### tb_bul_limits.sv
// tb_bul_limits: self-checking bench for the buffer usage limit block
`timescale 1ns/10ps
`default_nettype none
module tb_bul_limits import bul_pkg::*; ;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic ce = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [ADDR_W-1:0] paddr = '0;
   logic [31:0] pwdata = '0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   bul_usage_t usage = '0;
   logic [BUF_W-1:0] flood_usage = '0;
   bul_ingress_s ing = '0;
   logic [NPORT-1:0] drop_pkt;
   logic [NPORT-1:0] pause_req;
   logic [NPORT-1:0] resume_req;
   logic [NPORT-1:0] paused;
   logic flood_full;
   int n_mismatch = 0;
   int checked = 0;
   logic [31:0] rd;
   logic er;

   // 20 MHz core clock
   always #25 pclk = ~pclk;

   bul_limits #(.CW(32)) dut_u (.pclk(pclk), .presetn(presetn), .ce(ce),
      .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .usage(usage), .flood_usage(flood_usage),
      .ing(ing), .drop_pkt(drop_pkt), .pause_req(pause_req),
      .resume_req(resume_req), .paused(paused), .flood_full(flood_full));

   task automatic end_sim();
      $display("checks %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] seen,
      input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("unexpected %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // one apb transfer; request held until pready is seen high
   task automatic apb(input logic wr, input logic [ADDR_W-1:0] a,
      input logic [31:0] wd);
      int i;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      // pready and read data are taken at the completing edge itself
      for (i = 0; i < 20; i++) begin
         @(posedge pclk);
         if (pready === 1'b1) begin
            rd = prdata;
            er = pslverr;
            break;
         end
      end
      if (i == 20) begin
         n_mismatch++;
         end_sim();
      end
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rdchk(input logic [ADDR_W-1:0] a, input logic [31:0] e,
      input string nm);
      apb(1'b0, a, '0);
      chk(nm, rd, e);
      chk("read error", {31'h0, er}, 32'h0);
   endtask

   task automatic use3(input logic [8:0] a, b, c);
      @(posedge pclk);
      usage <= {c, b, a};
   endtask

   // one packet on port p; drop decision shows one cycle later
   task automatic pkt(input int p, input logic r, y, h, f, input logic e);
      @(posedge pclk);
      ing.start[p] <= 1'b1;
      ing.red[p] <= r;
      ing.yellow[p] <= y;
      ing.rnd_hit[p] <= h;
      ing.flood[p] <= f;
      @(posedge pclk);
      ing <= '0;
      #1;
      chk("drop_pkt", {31'h0, drop_pkt[p]}, {31'h0, e});
   endtask

   // set usage, then look at the flow control pulses of port 1
   task automatic fc(input logic [8:0] a, b, c, input logic ep, er_);
      use3(a, b, c);
      @(posedge pclk);
      #1;
      chk("pause_req", {31'h0, pause_req[1]}, {31'h0, ep});
      chk("resume_req", {31'h0, resume_req[1]}, {31'h0, er_});
   endtask

   task automatic s_regs();
      rdchk(A_DROP, {16'h0, RST_DROP_LO, RST_DROP_HI}, "drop");
      rdchk(A_PAUSE, 32'h0000_213C, "pause");
      rdchk(A_RESUME, 32'h0000_0307, "resume");
      rdchk(A_FLOOD, 32'h0000_0031, "flood");
      rdchk(A_CNT0, 32'h0, "cnt0 reset");
      rdchk(A_CNT2, 32'h0, "cnt2 reset");
      // reserved bits must not stick; defaults restored afterwards
      apb(1'b1, A_DROP, 32'hFFFF_FFFF);
      rdchk(A_DROP, 32'h0000_FFFF, "drop reserved");
      apb(1'b1, A_DROP, 32'h0000_4964);
      apb(1'b1, A_FLOOD, 32'hFFFF_FF55);
      rdchk(A_FLOOD, 32'h0000_0055, "flood reserved");
      apb(1'b1, A_FLOOD, 32'h0000_0031);
      apb(1'b1, A_CNT1, 32'h0000_0055);
      rdchk(A_CNT1, 32'h0, "cnt1 write");
      apb(1'b0, 16'h7020, '0);
      chk("unmapped error", {31'h0, er}, 32'h1);
      apb(1'b0, 16'h7005, '0);
      chk("misaligned error", {31'h0, er}, 32'h1);
   endtask

   task automatic s_drop();
      use3(9'h063, 9'h000, 9'h000);
      pkt(0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
      use3(9'h064, 9'h000, 9'h000);
      pkt(0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
      // a second port at exactly 36 buffers selects the low limit
      use3(9'h048, 9'h024, 9'h000);
      pkt(0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
      use3(9'h049, 9'h024, 9'h000);
      pkt(0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
      use3(9'h049, 9'h023, 9'h000);
      pkt(0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
      rdchk(A_CNT0, 32'h2, "cnt0 count");
      rdchk(A_CNT0, 32'h0, "cnt0 cleared");
   endtask

   task automatic s_flow();
      // let every port resume first
      use3(9'h000, 9'h000, 9'h000);
      repeat (4) @(posedge pclk);
      fc(9'h000, 9'h03B, 9'h000, 1'b0, 1'b0);
      fc(9'h000, 9'h03C, 9'h000, 1'b1, 1'b0);
      chk("paused", {31'h0, paused[1]}, 32'h1);
      fc(9'h000, 9'h03C, 9'h000, 1'b0, 1'b0);
      fc(9'h000, 9'h008, 9'h000, 1'b0, 1'b0);
      fc(9'h000, 9'h007, 9'h000, 1'b0, 1'b1);
      chk("resumed", {31'h0, paused[1]}, 32'h0);
      // ports 0 and 2 active: low pause and resume levels apply
      fc(9'h028, 9'h020, 9'h028, 1'b0, 1'b0);
      fc(9'h028, 9'h021, 9'h028, 1'b1, 1'b0);
      fc(9'h028, 9'h004, 9'h028, 1'b0, 1'b0);
      fc(9'h028, 9'h003, 9'h028, 1'b0, 1'b1);
      use3(9'h000, 9'h000, 9'h000);
   endtask

   task automatic s_flood();
      @(posedge pclk);
      flood_usage <= 9'h030;
      @(posedge pclk);
      #1;
      chk("flood_full", {31'h0, flood_full}, 32'h0);
      pkt(0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
      @(posedge pclk);
      flood_usage <= 9'h031;
      #1;
      chk("flood_full", {31'h0, flood_full}, 32'h1);
      pkt(0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1);
      pkt(0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
      @(posedge pclk);
      flood_usage <= 9'h000;
      rdchk(A_CNT0, 32'h1, "cnt0 flood");
   endtask

   // clock enable low: nothing is judged or counted until it returns
   task automatic s_hold();
      @(posedge pclk);
      ce <= 1'b0;
      usage <= {9'h000, 9'h000, 9'h064};
      ing.start[0] <= 1'b1;
      repeat (3) @(posedge pclk);
      ce <= 1'b1;
      ing <= '0;
      chk("frozen drop", {31'h0, drop_pkt[0]}, 32'h0);
      chk("frozen pause", {31'h0, paused[0]}, 32'h0);
      repeat (2) @(posedge pclk);
      chk("thawed pause", {31'h0, pause_req[0]}, 32'h1);
      use3(9'h000, 9'h000, 9'h000);
      rdchk(A_CNT0, 32'h0, "cnt0 frozen");
   endtask

   task automatic s_color();
      pkt(2, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
      apb(1'b1, A_CTRL, 32'h1);
      pkt(2, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1);
      pkt(2, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0);
      apb(1'b1, A_CTRL, 32'h3);
      pkt(2, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1);
      pkt(2, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
      // test preset: the read loads a value near the sign bit
      apb(1'b1, A_CTRL, 32'h4);
      rdchk(A_CNT2, 32'h2, "cnt2 count");
      rdchk(A_CNT2, 32'h7FFF_FFFC, "cnt2 preset");
      apb(1'b1, A_CTRL, 32'h0);
      rdchk(A_CNT2, 32'h7FFF_FFFC, "cnt2 after preset");
      rdchk(A_CNT2, 32'h0, "cnt2 cleared");
   endtask

   initial begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      s_regs();
      s_drop();
      s_flow();
      s_flood();
      s_hold();
      s_color();
      end_sim();
   end
endmodule
`default_nettype wire
